// >>> hw/sdwp_pkg.sv
/*
  Shared constants for the serial converter write port: frame layout,
  power modes, wake-up timing and state encodings.
  Assumes a 10 MHz system clock and a host that shifts 16-bit frames.
*/
package sdwp_pkg;

  // ---------------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------------
  localparam int unsigned FRAME_BITS      = 16;
  localparam int unsigned CODE_BITS       = 12;
  localparam int unsigned MODE_BITS       = 2;
  localparam int unsigned CNT_BITS        = 5;
  localparam int unsigned MODE_HI_POS     = 13;  // power_mode_bit1 at frame_bit13
  localparam int unsigned MODE_LO_POS     = 12;  // power_mode_bit0 at frame_bit12
  localparam int unsigned CODE_MSB_POS    = 11;  // code_msb
  localparam int unsigned CODE_LSB_POS    = 0;   // code_lsb
  localparam logic [CNT_BITS-1:0] LAST_EDGE_CNT = 5'h0F;  // count before the 16th edge

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [CODE_BITS-1:0]  CODE_RESET  = 12'h000;
  localparam logic [FRAME_BITS-1:0] FRAME_RESET = 16'h0000;

  // ---------------------------------------------------------------------
  // Power modes
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    SDWP_MODE_NORMAL = 2'b00,
    SDWP_MODE_1K     = 2'b01,
    SDWP_MODE_100K   = 2'b10,
    SDWP_MODE_HIZ    = 2'b11
  } sdwp_mode_t;

  typedef enum logic [1:0] {
    SDWP_ST_ACTIVE = 2'b00,
    SDWP_ST_WAKING = 2'b01,
    SDWP_ST_DOWN   = 2'b10
  } sdwp_state_t;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned WAKE_HI_SUPP_NS = 2500;  // 5 V supply
  localparam int unsigned WAKE_LO_SUPP_NS = 5000;  // 3 V supply
  localparam int unsigned WAIT_BITS       = 6;

  // Least times round up to whole cycles, never below one.
  function automatic logic [WAIT_BITS-1:0] ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c == 0) begin
      c = 1;
    end
    return c[WAIT_BITS-1:0];
  endfunction

  localparam logic [WAIT_BITS-1:0] WAKE_HI_CYC = ns_to_cycles(WAKE_HI_SUPP_NS);
  localparam logic [WAIT_BITS-1:0] WAKE_LO_CYC = ns_to_cycles(WAKE_LO_SUPP_NS);

endpackage

// >>> hw/sdwp_link_if.sv
/*
  Carrier between the shift-clock front end and the system-clock core.
  The word is stable whenever the toggle is stable; the core samples the
  toggle through a two-stage synchroniser before it reads the word.
*/
`timescale 1ns/1ps
interface sdwp_link_if;
  import sdwp_pkg::*;
  logic [FRAME_BITS-1:0] word;    // last complete frame
  logic                  toggle;  // flips once per complete frame

  modport rx   (output word, output toggle);
  modport core (input word, input toggle);
endinterface

// >>> hw/sdwp_shift_rx.sv
/*
  Shift-clock front end: shifts serial data on falling shift-clock edges
  while frame sync is low and hands each complete frame to the core.
  Assumes the shift clock may stop outside frames; frame sync high clears
  the frame logic asynchronously, so an abort needs no clock edge.
*/
`timescale 1ns/1ps
module sdwp_shift_rx
  import sdwp_pkg::*;
(
  input  wire logic      link_clk,      // wire_host_clock from the host
  input  wire logic      frame_sync_n,  // active-low frame sync
  input  wire logic      serial_data,   // serial data line
  input  wire logic      reset,         // system reset, clears the hand-over
  sdwp_link_if.rx        link           // complete frames to the core
);

  typedef struct packed {
    logic [FRAME_BITS-1:0] shift;
    logic [CNT_BITS-1:0]   count;
    logic                  done;
  } sdwp_frm_t;

  typedef struct packed {
    logic [FRAME_BITS-1:0] word;
    logic                  toggle;
  } sdwp_hand_t;

  sdwp_frm_t  frm_q, frm_d;
  sdwp_hand_t hand_q, hand_d;
  logic       last_edge;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    frm_d     = frm_q;
    hand_d    = hand_q;
    last_edge = !frm_q.done && (frm_q.count == LAST_EDGE_CNT);
    if (!frm_q.done) begin
      frm_d.shift = {frm_q.shift[FRAME_BITS-2:0], serial_data};
      frm_d.count = frm_q.count + 5'h01;
    end
    if (last_edge) begin
      frm_d.done    = 1'b1;
      hand_d.word   = {frm_q.shift[FRAME_BITS-2:0], serial_data};
      hand_d.toggle = ~hand_q.toggle;
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  // arm on sync fall
  // sync high clears frame
  // Sync is sampled as an asynchronous clear because the shift clock stands
  // still while the host holds sync high.
  always_ff @(negedge link_clk or posedge frame_sync_n or posedge reset) begin
    if (reset || frame_sync_n) begin
      frm_q <= '{shift: FRAME_RESET, count: '0, done: 1'b0};
    end else begin
      frm_q <= frm_d;
    end
  end

  always_ff @(negedge link_clk or posedge reset) begin
    if (reset) begin
      hand_q <= '{word: FRAME_RESET, toggle: 1'b0};
    end else begin
      hand_q <= hand_d;
    end
  end

  assign link.word   = hand_q.word;
  assign link.toggle = hand_q.toggle;

endmodule // sdwp_shift_rx

// >>> hw/sdwp_top.sv
/*
  Write port and control of a 12-bit voltage-output converter: receives
  16-bit frames on a three-wire serial link, holds the converter code and
  the power mode, and drives the output-stage controls.
  Assumes a 10 MHz system clock, a host-driven shift clock of its own
  phase, and a host that keeps the frame timing of the link.
*/
`timescale 1ns/1ps
module sdwp_top
  import sdwp_pkg::*;
(
  input  wire logic                 clk,              // 10 MHz system clock
  input  wire logic                 reset,            // synchronous in the core, asynchronous in the front end, active high
  input  wire logic                 wire_host_clock,  // shift clock from the host
  input  wire logic                 frame_sync_n,     // active-low frame sync
  input  wire logic                 serial_data_in,   // serial data line
  input  wire logic                 supply_low,       // high selects the 3 V wake-up time for wakes from power-down
  output logic [CODE_BITS-1:0]      code_q,           // stored converter code
  output logic [MODE_BITS-1:0]      power_mode_q,     // current power mode
  output logic                      amp_on_q,         // linear circuitry powered
  output logic                      out_to_amp_q,     // output pin tied to amplifier
  output logic                      term_1k_q,        // 1k load to ground selected
  output logic                      term_100k_q,      // 100k load to ground selected
  output logic                      out_hiz_q,        // output left open
  output logic                      out_valid_q,      // output settled and valid
  output logic                      frame_applied_q   // one-cycle pulse per applied frame
);

  // ---------------------------------------------------------------------
  // Shift-clock front end
  // ---------------------------------------------------------------------
  sdwp_link_if link ();

  sdwp_shift_rx u_rx (
    .link_clk     (wire_host_clock),
    .frame_sync_n (frame_sync_n),
    .serial_data  (serial_data_in),
    .reset        (reset),
    .link         (link.rx)
  );

  // ---------------------------------------------------------------------
  // Core state
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic                 tog_s1;
    logic                 tog_s2;
    logic                 tog_s3;
    logic                 sup_s1;
    logic                 sup_s2;
    sdwp_state_t          state;
    logic [WAIT_BITS-1:0] wait_cnt;
    logic [CODE_BITS-1:0] code;
    sdwp_mode_t           mode;
    logic                 amp_on;
    logic                 out_to_amp;
    logic                 term_1k;
    logic                 term_100k;
    logic                 out_hiz;
    logic                 out_valid;
    logic                 applied;
  } sdwp_core_t;

  // Reset starts a wake-up count of WAKE_HI_CYC, the 5 V time, even when supply_low is high,
  // so the output is not flagged valid until that many cycles after power-up.
  localparam sdwp_core_t CORE_RESET = '{
    tog_s1:     1'b0,
    tog_s2:     1'b0,
    tog_s3:     1'b0,
    sup_s1:     1'b0,
    sup_s2:     1'b0,
    state:      SDWP_ST_WAKING,
    wait_cnt:   WAKE_HI_CYC,
    code:       CODE_RESET,
    mode:       SDWP_MODE_NORMAL,
    amp_on:     1'b1,
    out_to_amp: 1'b1,
    term_1k:    1'b0,
    term_100k:  1'b0,
    out_hiz:    1'b0,
    out_valid:  1'b0,
    applied:    1'b0
  };

  sdwp_core_t core_q, core_d;

  // Output stage controls follow the mode; one function keeps the decode in one place.
  // Bit order of the control word: amplifier on, output to amplifier, 1k load,
  // 100k load, open output.
  function automatic logic [4:0] stage_ctl(input sdwp_mode_t m);
    logic [4:0] c;
    c = 5'h00;
    unique case (m)
      SDWP_MODE_NORMAL: c = 5'h18;  // amp on, output to amp
      SDWP_MODE_1K:     c = 5'h04;
      SDWP_MODE_100K:   c = 5'h02;
      SDWP_MODE_HIZ:    c = 5'h01;
    endcase
    return c;
  endfunction

  logic                 new_frame;
  logic [MODE_BITS-1:0] frm_mode;
  logic [CODE_BITS-1:0] frm_code;
  logic [WAIT_BITS-1:0] wake_cyc;
  logic [4:0]           ctl;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    core_d        = core_q;
    core_d.tog_s1 = link.toggle;
    core_d.tog_s2 = core_q.tog_s1;
    core_d.tog_s3 = core_q.tog_s2;
    core_d.sup_s1 = supply_low;
    core_d.sup_s2 = core_q.sup_s1;
    core_d.applied = 1'b0;

    // The word is read only after the toggle has crossed, so it has been
    // stable for at least two system clocks; a new frame needs 16 shift
    // edges before the word can move again.
    new_frame = core_q.tog_s2 ^ core_q.tog_s3;
    frm_mode  = link.word[MODE_HI_POS:MODE_LO_POS];
    frm_code  = link.word[CODE_MSB_POS:CODE_LSB_POS];
    wake_cyc  = core_q.sup_s2 ? WAKE_LO_CYC : WAKE_HI_CYC;

    unique case (core_q.state)
      SDWP_ST_WAKING: begin
        if (core_q.wait_cnt <= 6'h01) begin
          core_d.state     = SDWP_ST_ACTIVE;
          core_d.wait_cnt  = 6'h00;
          core_d.out_valid = 1'b1;
        end else begin
          core_d.wait_cnt = core_q.wait_cnt - 6'h01;
        end
      end
      SDWP_ST_ACTIVE: begin
        core_d.out_valid = 1'b1;
      end
      SDWP_ST_DOWN: begin
        core_d.out_valid = 1'b0;
      end
      default: begin
        core_d.state     = SDWP_ST_DOWN;
        core_d.out_valid = 1'b0;
      end
    endcase

    if (new_frame) begin
      core_d.applied = 1'b1;
      core_d.mode    = sdwp_mode_t'(frm_mode);
      if (frm_mode == SDWP_MODE_NORMAL) begin
        core_d.code = frm_code;
        if (core_q.state == SDWP_ST_DOWN) begin
          core_d.state     = SDWP_ST_WAKING;
          core_d.wait_cnt  = wake_cyc;
          core_d.out_valid = 1'b0;
        end
      end else begin
        core_d.state     = SDWP_ST_DOWN;
        core_d.wait_cnt  = 6'h00;
        core_d.out_valid = 1'b0;
      end
    end

    ctl               = stage_ctl(core_d.mode);
    core_d.amp_on     = ctl[4];
    core_d.out_to_amp = ctl[3];
    core_d.term_1k    = ctl[2];
    core_d.term_100k  = ctl[1];
    core_d.out_hiz    = ctl[0];
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  // zero code after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      core_q <= CORE_RESET;
    end else begin
      core_q <= core_d;
    end
  end

  assign code_q          = core_q.code;
  assign power_mode_q    = core_q.mode;
  assign amp_on_q        = core_q.amp_on;
  assign out_to_amp_q    = core_q.out_to_amp;
  assign term_1k_q       = core_q.term_1k;
  assign term_100k_q     = core_q.term_100k;
  assign out_hiz_q       = core_q.out_hiz;
  assign out_valid_q     = core_q.out_valid;
  assign frame_applied_q = core_q.applied;

endmodule // sdwp_top

// >>> dv/sdwp_top_properties.sv
/*
  Concurrent checks on the ports of the converter write port.
  Assumes it is bound to sdwp_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module sdwp_top_chk
  import sdwp_pkg::*;
(
  input wire logic                 clk,              // system clock
  input wire logic                 reset,            // synchronous reset
  input wire logic                 wire_host_clock,  // shift clock
  input wire logic                 frame_sync_n,     // frame sync
  input wire logic                 serial_data_in,   // serial data
  input wire logic                 supply_low,       // wake-up time select
  input wire logic [CODE_BITS-1:0] code_q,           // stored code
  input wire logic [MODE_BITS-1:0] power_mode_q,     // power mode
  input wire logic                 amp_on_q,         // amplifier on
  input wire logic                 out_to_amp_q,     // output on amplifier
  input wire logic                 term_1k_q,        // 1k load
  input wire logic                 term_100k_q,      // 100k load
  input wire logic                 out_hiz_q,        // open output
  input wire logic                 out_valid_q,      // output valid
  input wire logic                 frame_applied_q   // frame pulse
);
  // ---------------------------------------------------------------------
  // Wake-up counter
  // ---------------------------------------------------------------------
  logic [7:0] wait_cnt_q;
  logic [7:0] wait_cnt_d;
  always_comb begin
    wait_cnt_d = (amp_on_q && !out_valid_q) ? wait_cnt_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk) begin
    wait_cnt_q <= reset ? 8'h00 : wait_cnt_d;
  end

  default clocking chk_cb @(posedge clk); endclocking
  default disable iff (reset);

  a_reset_zero: assert property (
    $fell(reset) |-> code_q == CODE_RESET && power_mode_q == 2'h0 && !out_valid_q)
    else $error("code or mode wrong after reset");
  a_code_needs_apply: assert property (
    !frame_applied_q |-> $stable(code_q)) else $error("code moved without a frame");
  a_mode_needs_apply: assert property (
    !frame_applied_q |-> $stable(power_mode_q)) else $error("mode moved without a frame");
  a_down_keeps_code: assert property (
    frame_applied_q && power_mode_q != SDWP_MODE_NORMAL |-> $stable(code_q))
    else $error("power-down frame altered code");
  a_term_decode: assert property (
    term_1k_q == (power_mode_q == SDWP_MODE_1K) && term_100k_q == (power_mode_q == SDWP_MODE_100K)
    && out_hiz_q == (power_mode_q == SDWP_MODE_HIZ)) else $error("termination does not match mode");
  a_amp_follow_mode: assert property (
    amp_on_q == (power_mode_q == SDWP_MODE_NORMAL) && out_to_amp_q == amp_on_q)
    else $error("amplifier state does not match mode");
  a_wake_hold_low: assert property (
    $rose(amp_on_q) |-> !out_valid_q [*8]) else $error("output valid too soon after wake");
  a_wake_time: assert property (
    $rose(out_valid_q) |-> wait_cnt_q == {2'h0, WAKE_HI_CYC} || wait_cnt_q == {2'h0, WAKE_LO_CYC})
    else $error("wake-up delay out of range");
  a_pulse_single: assert property (
    frame_applied_q |=> !frame_applied_q [*3]) else $error("frame pulse too long");
endmodule // sdwp_top_chk

bind sdwp_top sdwp_top_chk sdwp_top_chk_i (.clk, .reset, .wire_host_clock, .frame_sync_n, .serial_data_in,
  .supply_low, .code_q, .power_mode_q, .amp_on_q, .out_to_amp_q, .term_1k_q, .term_100k_q, .out_hiz_q,
  .out_valid_q, .frame_applied_q);

// >>> dv/sdwp_host_model.sv
/*
  Behavioural serial host that writes frames to the converter port.
  Assumes its tasks are called from one bench process at a time.
*/
`timescale 1ns/1ps
module sdwp_host_model (
  output logic wire_host_clock,  // shift clock, still outside frames
  output logic frame_sync_n,     // active-low frame sync
  output logic serial_data_in    // serial data
);
  localparam time HALF = 3ns;
  initial begin
    wire_host_clock = 1'b0;
    frame_sync_n    = 1'b1;
    serial_data_in  = 1'b0;
  end
  task automatic begin_frame();
    frame_sync_n = 1'b1;
    #40;
    frame_sync_n = 1'b0;
    #HALF;
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      wire_host_clock = 1'b1;
      serial_data_in  = b[i];
      #HALF;
      wire_host_clock = 1'b0;
      #HALF;
    end
    // A released line must not keep its last bit, or a stale sample could pass.
    serial_data_in = ~serial_data_in;
  endtask
  task automatic extra_clocks(input int n);
    repeat (n) begin
      wire_host_clock = 1'b1;
      serial_data_in  = ~serial_data_in;
      #HALF;
      wire_host_clock = 1'b0;
      #HALF;
    end
  endtask
  task automatic end_frame(input logic hold_low);
    #HALF;
    if (!hold_low) begin
      frame_sync_n = 1'b1;
    end
  endtask
endmodule // sdwp_host_model

// >>> dv/sdwp_top_bench.sv
/*
  Self-checking bench for the converter write port.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module sdwp_top_bench
  import sdwp_pkg::*;
();
  logic                 clk = 1'b0;
  logic                 reset;
  logic                 supply_low = 1'b0;
  logic                 sclk, sync_n, sdata;
  logic [CODE_BITS-1:0] code_q;
  logic [MODE_BITS-1:0] power_mode_q;
  logic                 amp_on_q, out_to_amp_q, term_1k_q, term_100k_q, out_hiz_q, out_valid_q, frame_applied_q;
  int                   err_total = 0;
  int                   comparisons = 0;

  always #50 clk = ~clk;

  sdwp_host_model sdwp_host_model_i (.wire_host_clock(sclk), .frame_sync_n(sync_n), .serial_data_in(sdata));
  sdwp_top sdwp_top_i (.clk(clk), .reset(reset), .wire_host_clock(sclk), .frame_sync_n(sync_n),
    .serial_data_in(sdata), .supply_low(supply_low), .code_q(code_q), .power_mode_q(power_mode_q),
    .amp_on_q(amp_on_q), .out_to_amp_q(out_to_amp_q), .term_1k_q(term_1k_q), .term_100k_q(term_100k_q),
    .out_hiz_q(out_hiz_q), .out_valid_q(out_valid_q), .frame_applied_q(frame_applied_q));

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic write_frame(input logic [1:0] md, input logic [11:0] cd, input logic split, input logic hold);
    sdwp_host_model_i.begin_frame();
    sdwp_host_model_i.send_byte({2'b11, md, cd[11:8]});
    if (split) begin
      #500;
    end
    sdwp_host_model_i.send_byte(cd[7:0]);
    sdwp_host_model_i.end_frame(hold);
  endtask
  task automatic wait_apply(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(negedge clk);
      if (frame_applied_q === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    `CHK("frame_applied_q", exp, seen)
  endtask
  task automatic check_state(input logic [1:0] md, input logic [11:0] cd);
    logic [4:0] ctl;
    ctl = {md == 2'b00, md == 2'b00, md == 2'b01, md == 2'b10, md == 2'b11};
    `CHK("code_q", cd, code_q)
    `CHK("power_mode_q", md, power_mode_q)
    `CHK("output controls", ctl, {amp_on_q, out_to_amp_q, term_1k_q, term_100k_q, out_hiz_q})
  endtask
  task automatic wait_valid(input int lo);
    repeat (lo) @(negedge clk);
    `CHK("out_valid_q early", 1'b0, out_valid_q)
    repeat (30) begin
      if (out_valid_q === 1'b1) break;
      @(negedge clk);
    end
    `CHK("out_valid_q", 1'b1, out_valid_q)
  endtask

  // ---------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------
  initial begin
    logic [11:0] codes [2];
    // Reset rises as an event so that the link-side flops, which clear on its edge, start known.
    reset <= 1'b1;
    codes = '{12'hFFF, 12'hABC};
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check_state(2'b00, 12'h000);
    wait_valid(20);
    foreach (codes[i]) begin
      write_frame(2'b00, codes[i], 1'b0, 1'b0);
      wait_apply(1'b1);
      check_state(2'b00, codes[i]);
      `CHK("out_valid_q normal", 1'b1, out_valid_q)
    end
    for (int m = 1; m < 4; m++) begin
      write_frame(m[1:0], 12'h555, 1'b0, 1'b0);
      wait_apply(1'b1);
      check_state(m[1:0], 12'hABC);
      `CHK("out_valid_q down", 1'b0, out_valid_q)
    end
    @(posedge clk);
    supply_low <= 1'b1;
    write_frame(2'b00, 12'h5A5, 1'b1, 1'b1);
    wait_apply(1'b1);
    check_state(2'b00, 12'h5A5);
    wait_valid(45);
    sdwp_host_model_i.begin_frame();
    sdwp_host_model_i.send_byte(8'h0F);
    sdwp_host_model_i.end_frame(1'b0);
    wait_apply(1'b0);
    check_state(2'b00, 12'h5A5);
    write_frame(2'b00, 12'h123, 1'b0, 1'b1);
    wait_apply(1'b1);
    check_state(2'b00, 12'h123);
    sdwp_host_model_i.extra_clocks(16);
    wait_apply(1'b0);
    check_state(2'b00, 12'h123);
    sdwp_host_model_i.end_frame(1'b0);
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check_state(2'b00, 12'h000);
    wait_valid(20);
    write_frame(2'b00, 12'h321, 1'b0, 1'b0);
    wait_apply(1'b1);
    check_state(2'b00, 12'h321);
    tally_and_finish();
  end

  initial begin
    #2_000_000;
    err_total++;
    tally_and_finish();
  end
endmodule // sdwp_top_bench
